// File: rtl/dtc_timer.sv
// two timer/counters with external interrupt detect, AHB-Lite slave
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "dtc_consts.svh"
// How it works
// - each timer sets its overflow flag, bit 7 or bit 5, on overflow
// - overflow flag clears when that timer's service routine is entered
// - software writes set or clear either overflow flag directly
// - run bits 6 and 4 start and stop their timers
// - edge mode sets detect flag bit 3 or 1 on a detected edge
// - edge flag clears on service entry; in level mode flag tracks pin
// - trigger-type bits 2 and 0 choose edge or level triggering
// - mode register: timer one upper nibble, timer zero lower nibble
// - gate set: count only while interrupt pin high and run set
// - gate clear: interrupt pin ignored, count whenever run is set
// - source select 0 counts internal clock, 1 counts count-pin falls
// - mode 00 is an 8-bit counter with low byte as 5-bit prescaler
module dtc_timer
  import dtc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire dtc_pins_t pins,
  input wire logic [1:0] isr_enter_t,
  input wire logic [1:0] isr_enter_x,
  output logic irq
);
  logic [7:0] mode_r;
  logic [7:0] ctrl_r;
  logic [3:0] stat_r;
  logic [3:0] mask_r;
  logic [4:0] pre_r [2];
  logic [7:0] high_r [2];
  logic [3:0] div_r;
  logic tick;
  dtc_pins_t pins_q;
  logic wr_pend_r;
  logic [7:0] wa_r;
  logic [31:0] rd_nxt;
  logic [1:0] ovf;
  logic [1:0] xedge;
  logic [1:0] cnt_en;
  logic [1:0] run;
  logic [1:0] xt;
  logic [1:0] xp;
  logic [1:0] xpq;
  logic [1:0] cp;
  logic [1:0] cpq;
  dtc_nib_t nib [2];
  logic acc;
  logic wr_mode;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;

  // bus: always zero wait, always OKAY
  // one register per word: address bits 9 to 2 carry the index
  assign acc = hsel && hready && htrans[1];
  assign wr_mode = wr_pend_r && (wa_r == `DTC_OFS_MODE);
  assign wr_ctrl = wr_pend_r && (wa_r == `DTC_OFS_CTRL);
  assign wr_stat = wr_pend_r && (wa_r == `DTC_OFS_IRQ_STAT);
  assign wr_mask = wr_pend_r && (wa_r == `DTC_OFS_IRQ_MASK);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wr_pend_r <= 1'b0;
      wa_r <= 8'h00;
    end
    else
    begin
      wr_pend_r <= acc && hwrite;
      if (acc)
        wa_r <= haddr[9:2];
    end
  end

  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    case (haddr[9:2])
      `DTC_OFS_MODE: rd_nxt = {24'h000000, mode_r};
      `DTC_OFS_CTRL: rd_nxt = {24'h000000, ctrl_r};
      `DTC_OFS_IRQ_STAT: rd_nxt = {28'h0000000, stat_r};
      `DTC_OFS_IRQ_MASK: rd_nxt = {28'h0000000, mask_r};
      `DTC_OFS_HIGH0: rd_nxt = {19'h00000, high_r[0], pre_r[0]};
      `DTC_OFS_HIGH1: rd_nxt = {19'h00000, high_r[1], pre_r[1]};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // read data registered in the address phase so it stands in data phase
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (acc && !hwrite)
        hrdata <= rd_nxt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      mode_r <= `DTC_MODE_RST;
    else if (wr_mode)
      mode_r <= hwdata[7:0];
  end

  assign nib[1] = mode_r[7:4];
  assign nib[0] = mode_r[3:0];
  assign run = {ctrl_r[`DTC_BIT_T1_RUN], ctrl_r[`DTC_BIT_T0_RUN]};
  assign xt = {ctrl_r[`DTC_BIT_XT1], ctrl_r[`DTC_BIT_XT0]};
  assign xp = {pins.xirq1, pins.xirq0};
  assign xpq = {pins_q.xirq1, pins_q.xirq0};
  assign cp = {pins.cnt1, pins.cnt0};
  assign cpq = {pins_q.cnt1, pins_q.cnt0};

  // internal time base: one pulse every twelve clocks
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      div_r <= 4'h0;
      pins_q <= '1;
    end
    else
    begin
      div_r <= (div_r == `DTC_TICK_DIV) ? 4'h0 : div_r + 4'h1;
      pins_q <= pins;
    end
  end
  assign tick = (div_r == `DTC_TICK_DIV);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_tmr
      logic src_ev;
      // gate high needs the interrupt pin high as well as run
      assign src_ev = nib[gi].csrc ? (cpq[gi] && !cp[gi]) : tick;
      assign cnt_en[gi] = run[gi] && (!nib[gi].gate || xp[gi])
        && src_ev;
      assign ovf[gi] = cnt_en[gi] && (nib[gi].mode == 2'b00)
        && (pre_r[gi] == `DTC_PRESCALE_MAX) && (high_r[gi] == 8'hFF);
      // falling edge when type is 1, else flag follows the low level
      assign xedge[gi] = xt[gi] && xpq[gi] && !xp[gi];

      // other modes are not implemented: counter holds
      always_ff @(posedge sys_clk)
      begin
        if (!rst_n)
        begin
          pre_r[gi] <= 5'h00;
          high_r[gi] <= 8'h00;
        end
        else if (cnt_en[gi] && nib[gi].mode == 2'b00)
        begin
          pre_r[gi] <= pre_r[gi] + 5'h01;
          if (pre_r[gi] == `DTC_PRESCALE_MAX)
            high_r[gi] <= high_r[gi] + 8'h01;
        end
      end
    end
  endgenerate

  // run, flags and trigger types; hardware sets win over any clear
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      ctrl_r <= `DTC_CTRL_RST;
    else
    begin
      if (wr_ctrl)
        ctrl_r <= hwdata[7:0];
      if (isr_enter_t[1])
        ctrl_r[`DTC_BIT_T1_OVF] <= 1'b0;
      if (isr_enter_t[0])
        ctrl_r[`DTC_BIT_T0_OVF] <= 1'b0;
      if (ovf[1])
        ctrl_r[`DTC_BIT_T1_OVF] <= 1'b1;
      if (ovf[0])
        ctrl_r[`DTC_BIT_T0_OVF] <= 1'b1;
      if (!xt[1])
        ctrl_r[`DTC_BIT_XF1] <= !xp[1];
      else if (xedge[1])
        ctrl_r[`DTC_BIT_XF1] <= 1'b1;
      else if (isr_enter_x[1])
        ctrl_r[`DTC_BIT_XF1] <= 1'b0;
      if (!xt[0])
        ctrl_r[`DTC_BIT_XF0] <= !xp[0];
      else if (xedge[0])
        ctrl_r[`DTC_BIT_XF0] <= 1'b1;
      else if (isr_enter_x[0])
        ctrl_r[`DTC_BIT_XF0] <= 1'b0;
    end
  end

  // sticky events: {xirq1 edge, xirq0 edge, t1 ovf, t0 ovf}
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      stat_r <= 4'h0;
      mask_r <= 4'h0;
      irq <= 1'b0;
    end
    else
    begin
      if (wr_mask)
        mask_r <= hwdata[3:0];
      stat_r <= (stat_r & ~(wr_stat ? hwdata[3:0] : 4'h0))
        | {xedge, ovf};
      irq <= |(stat_r & mask_r);
    end
  end

  property p_ovf_sets;
    @(posedge sys_clk) disable iff (!rst_n)
    ovf[1] |=> ctrl_r[`DTC_BIT_T1_OVF];
  endproperty
  a_ovf_sets: assert property (p_ovf_sets)
    else $error("t1 overflow flag not set");

  property p_isr_clr;
    @(posedge sys_clk) disable iff (!rst_n)
    (isr_enter_t[0] && !ovf[0] && !wr_ctrl) |=> !ctrl_r[`DTC_BIT_T0_OVF];
  endproperty
  a_isr_clr: assert property (p_isr_clr)
    else $error("t0 overflow flag not cleared on entry");

  property p_sw_write;
    @(posedge sys_clk) disable iff (!rst_n)
    (wr_ctrl && !ovf[0] && !isr_enter_t[0])
      |=> ctrl_r[`DTC_BIT_T0_OVF] == $past(hwdata[`DTC_BIT_T0_OVF]);
  endproperty
  a_sw_write: assert property (p_sw_write)
    else $error("software write to overflow flag lost");

  property p_stopped;
    @(posedge sys_clk) disable iff (!rst_n)
    !run[0] |=> $stable(pre_r[0]);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("timer zero moved while stopped");

  property p_edge_set;
    @(posedge sys_clk) disable iff (!rst_n)
    xedge[1] |=> ctrl_r[`DTC_BIT_XF1];
  endproperty
  a_edge_set: assert property (p_edge_set)
    else $error("edge flag not set");

  property p_level;
    @(posedge sys_clk) disable iff (!rst_n)
    !xt[0] |=> ctrl_r[`DTC_BIT_XF0] == !$past(xp[0]);
  endproperty
  a_level: assert property (p_level)
    else $error("level flag does not track pin");

  property p_gate;
    @(posedge sys_clk) disable iff (!rst_n)
    (nib[0].gate && !xp[0]) |=> $stable(pre_r[0]);
  endproperty
  a_gate: assert property (p_gate)
    else $error("gated timer counted with pin low");

  sequence s_wrap;
    cnt_en[0] && nib[0].mode == 2'b00 && pre_r[0] == `DTC_PRESCALE_MAX;
  endsequence
  property p_wrap;
    @(posedge sys_clk) disable iff (!rst_n)
    s_wrap |=> pre_r[0] == 5'h00 && high_r[0] == $past(high_r[0]) + 8'h01;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("prescale wrap did not step high byte");

  property p_map;
    @(posedge sys_clk) disable iff (!rst_n)
    wr_mode |=> nib[1].gate == $past(hwdata[7]);
  endproperty
  a_map: assert property (p_map)
    else $error("mode nibble layout wrong");

  property p_ext;
    @(posedge sys_clk) disable iff (!rst_n)
    (nib[0].csrc && run[0] && !nib[0].gate && !(cpq[0] && !cp[0]))
      |=> $stable(pre_r[0]);
  endproperty
  a_ext: assert property (p_ext)
    else $error("counter moved without pin fall");

  property p_run1;
    @(posedge sys_clk) disable iff (!rst_n)
    !run[1] |=> $stable(pre_r[1]);
  endproperty
  a_run1: assert property (p_run1)
    else $error("timer one moved while stopped");

  property p_xisr;
    @(posedge sys_clk) disable iff (!rst_n)
    (isr_enter_x[1] && xt[1] && !xedge[1]) |=> !ctrl_r[`DTC_BIT_XF1];
  endproperty
  a_xisr: assert property (p_xisr)
    else $error("edge flag not cleared on entry");

  property p_tick;
    @(posedge sys_clk) disable iff (!rst_n)
    tick |-> ##12 tick;
  endproperty
  a_tick: assert property (p_tick)
    else $error("time base period wrong");

  property p_tick_inc;
    @(posedge sys_clk) disable iff (!rst_n)
    (tick && run[0] && !nib[0].csrc && nib[0].mode == 2'b00 && xp[0])
      |=> pre_r[0] == $past(pre_r[0]) + 5'h01;
  endproperty
  a_tick_inc: assert property (p_tick_inc)
    else $error("timer zero missed a tick");

  property p_no_tick;
    @(posedge sys_clk) disable iff (!rst_n)
    (!nib[0].csrc && !tick) |=> $stable(pre_r[0]);
  endproperty
  a_no_tick: assert property (p_no_tick)
    else $error("timer zero moved without a tick");

  property p_stat;
    @(posedge sys_clk) disable iff (!rst_n)
    ovf[1] |=> stat_r[1];
  endproperty
  a_stat: assert property (p_stat)
    else $error("overflow event not latched");

  property p_irq;
    @(posedge sys_clk) disable iff (!rst_n)
    (|(stat_r & mask_r)) |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt not raised");
endmodule : dtc_timer

// File: rtl/dtc_consts.svh
// register word indexes, field positions and timing counts for the timer block
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH
`define DTC_OFS_MODE 8'h89
`define DTC_OFS_CTRL 8'h88
`define DTC_OFS_IRQ_STAT 8'hA0
`define DTC_OFS_IRQ_MASK 8'hA4
`define DTC_OFS_HIGH0 8'hA8
`define DTC_OFS_HIGH1 8'hAC
`define DTC_BIT_T1_OVF 7
`define DTC_BIT_T1_RUN 6
`define DTC_BIT_T0_OVF 5
`define DTC_BIT_T0_RUN 4
`define DTC_BIT_XF1 3
`define DTC_BIT_XT1 2
`define DTC_BIT_XF0 1
`define DTC_BIT_XT0 0
`define DTC_BIT_GATE 3
`define DTC_BIT_CSRC 2
`define DTC_MODE_RST 8'h00
`define DTC_CTRL_RST 8'h00
`define DTC_TICK_DIV 4'hB
`define DTC_PRESCALE_MAX 5'h1F
`endif

// File: rtl/dtc_pkg.sv
// types shared by the timer block
package dtc_pkg;
  typedef struct packed {
    logic gate;
    logic csrc;
    logic [1:0] mode;
  } dtc_nib_t;
  typedef struct packed {
    logic xirq1;
    logic xirq0;
    logic cnt1;
    logic cnt0;
  } dtc_pins_t;
  typedef enum logic [1:0] {
    DTC_PH_IDLE = 2'b00,
    DTC_PH_DATA = 2'b01
  } dtc_phase_t;
endpackage : dtc_pkg

// File: tb/dtc_pin_model.sv
// far-side model: count pins and external interrupt pins
`timescale 1ns/10ps
module dtc_pin_model
  import dtc_pkg::*;
(
  input wire logic sys_clk,
  output dtc_pins_t pins
);
  // pins idle high, as with pull-ups on the board
  initial pins = 4'hF;
  // n falling edges; each level held hold cycles so slow sources are covered
  task automatic falls(input bit one, input int n, input int hold);
    for (int i = 0; i < 2 * n * hold; i++)
    begin
      @(posedge sys_clk);
      if (one)
        pins.cnt1 <= ((i / hold) % 2);
      else
        pins.cnt0 <= ((i / hold) % 2);
    end
  endtask : falls
  task automatic xset(input bit one, input logic v);
    @(posedge sys_clk);
    if (one)
      pins.xirq1 <= v;
    else
      pins.xirq0 <= v;
  endtask : xset
endmodule : dtc_pin_model

// File: tb/tb_dual_timer_control_ext_irq.sv
// testbench for the two-timer control block
`timescale 1ns/10ps
module tb_dual_timer_control_ext_irq;
  import dtc_pkg::*;
  logic sys_clk, rst_n, hsel, hwrite, hready, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans, isr_enter_t, isr_enter_x;
  logic [2:0] hsize;
  dtc_pins_t pins;
  int fails = 0;
  int tests_run = 0;
  dtc_timer dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .pins(pins),
    .isr_enter_t(isr_enter_t), .isr_enter_x(isr_enter_x), .irq(irq));
  dtc_pin_model pm_u (.sys_clk(sys_clk), .pins(pins));
  initial
  begin
    sys_clk = 0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] s, e);
    tests_run++;
    if (s !== e)
    begin
      $display("BAD %s expected %h seen %h", nm, e, s);
      fails++;
    end
  endtask : chk
  // ready is sampled at the edge; a stuck slave ends the run
  task automatic wait_rdy;
    for (int i = 0; i < 20; i++)
    begin
      @(posedge sys_clk);
      if (hready === 1'b1)
        return;
    end
    fails++;
    end_sim();
  endtask : wait_rdy
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    // registers sit one word apart: byte address is four times the index
    haddr <= {22'h0, a, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask : ahb
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    ahb(1'b0, a, 32'h00000000);
    chk(nm, r, e);
  endtask : rd
  task automatic pulse(input logic t, input logic [1:0] v);
    if (t)
      isr_enter_t <= v;
    else
      isr_enter_x <= v;
    @(posedge sys_clk);
    isr_enter_t <= 2'h0;
    isr_enter_x <= 2'h0;
    repeat (2) @(posedge sys_clk);
  endtask : pulse
  task automatic t_counting;
    ahb(1'b1, 8'h89, 32'h0000004C);
    rd(8'h89, 32'h0000004C, "mode");
    ahb(1'b1, 8'h88, 32'h00000050);
    pm_u.xset(1'b0, 1'b0);
    pm_u.falls(1'b0, 5, 1);
    rd(8'hA8, 32'h00000000, "gated count0");
    pm_u.xset(1'b0, 1'b1);
    pm_u.falls(1'b0, 3, 2);
    rd(8'hA8, 32'h00000003, "count0");
    pm_u.falls(1'b1, 33, 1);
    rd(8'hAC, 32'h00000021, "count1");
    rd(8'h88, 32'h00000050, "ctrl run");
  endtask : t_counting
  task automatic t_overflow;
    pm_u.falls(1'b1, 8192 - 33, 1);
    repeat (2) @(posedge sys_clk);
    rd(8'h88, 32'h000000D0, "ovf flag");
    rd(8'hAC, 32'h00000000, "count1 wrap");
    ahb(1'b0, 8'hA0, 32'h00000000);
    chk("ovf status", r & 32'h3, 32'h00000002);
    chk("irq masked", irq, 1'b0);
    ahb(1'b1, 8'hA4, 32'h00000002);
    repeat (2) @(posedge sys_clk);
    chk("irq", irq, 1'b1);
    pulse(1'b1, 2'b11);
    rd(8'h88, 32'h00000050, "isr clear");
    ahb(1'b1, 8'hA0, 32'h00000002);
    repeat (2) @(posedge sys_clk);
    chk("irq cleared", irq, 1'b0);
  endtask : t_overflow
  task automatic t_flags;
    ahb(1'b1, 8'h88, 32'h000000A0);
    rd(8'h88, 32'h000000A0, "sw set");
    ahb(1'b1, 8'h88, 32'h00000004);
    rd(8'h88, 32'h00000004, "sw clear");
    pm_u.xset(1'b1, 1'b0);
    pm_u.xset(1'b1, 1'b1);
    repeat (2) @(posedge sys_clk);
    rd(8'h88, 32'h0000000C, "edge flag");
    rd(8'hA0, 32'h00000008, "edge status");
    pulse(1'b0, 2'b10);
    rd(8'h88, 32'h00000004, "edge isr");
    pm_u.xset(1'b0, 1'b0);
    repeat (2) @(posedge sys_clk);
    rd(8'h88, 32'h00000006, "level low");
    pm_u.xset(1'b0, 1'b1);
    repeat (2) @(posedge sys_clk);
    rd(8'h88, 32'h00000004, "level high");
  endtask : t_flags
  // gate pin held high for exactly 36 clocks: three internal ticks
  task automatic t_tick;
    ahb(1'b1, 8'h89, 32'h00000048);
    pm_u.xset(1'b0, 1'b0);
    ahb(1'b1, 8'h88, 32'h00000014);
    pm_u.xset(1'b0, 1'b1);
    repeat (35) @(posedge sys_clk);
    pm_u.xset(1'b0, 1'b0);
    rd(8'hA8, 32'h00000006, "tick count0");
  endtask : t_tick
  initial
  begin
    rst_n = 0;
    hsel = 0;
    haddr = 0;
    htrans = 0;
    hwrite = 0;
    hsize = 3'h2;
    hwdata = 0;
    isr_enter_t = 0;
    isr_enter_x = 0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(8'h88, 32'h00000000, "ctrl reset");
    rd(8'h89, 32'h00000000, "mode reset");
    rd(8'h90, 32'h00000000, "unmapped");
    t_counting();
    t_overflow();
    t_flags();
    t_tick();
    end_sim();
  end
endmodule : tb_dual_timer_control_ext_irq
